//--- verilog/timer_irq_enable_status.sv
// Notes on behaviour
// - Bits 1..4 of the enable register gate each channel interrupt.
// - Bit 5 of the enable register gates the capture/compare update interrupt.
// - Update flag at status bit 0 set by hardware, cleared by software only.
// - Repetition counter overflow/underflow sets update flag unless updates are disabled.
// - Software update request sets update flag when not disabled and source select zero.
// - Trigger reinitialization sets update flag when not disabled and source select zero.
// - Output channel flag sets when counter matches its compare value.
// - Input channel flag sets on each input capture event.
// - Channel flag clears by software writing zero or reading its compare register.
// - Channels 2..4 flags at bits 2..4 behave like channel 1.
// - Capture/compare update flag at bit 5, hardware set, software clear.
// - Trigger flag at bit 6, hardware set, software clear.
// - Break flag at bit 7 set while break input is active.
// - Break flag cannot be cleared while break input remains active.
module timer_irq_enable_status
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [timer_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [timer_irq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire timer_irq_pkg::timer_events_t events,
  input wire timer_irq_pkg::update_ctrl_t update_ctrl,
  output logic update_event,
  output logic counter_reinit,
  output logic irq
);
  import timer_irq_pkg::*;

  logic [NUM_SRC-1:0] enable_r;
  logic [NUM_SRC-1:0] flags_r;
  logic [NUM_SRC-1:0] flags_nxt;
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic update_event_r;
  logic counter_reinit_r;
  logic irq_r;
  logic bvalid_r;
  logic awready_r;
  logic wready_r;
  logic arready_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Byte-lane merge, used only for the enable register (its write and the irq lookahead).
  function automatic logic [NUM_SRC-1:0] lane0(input logic [3:0] strb,
                                                input logic [31:0] data,
                                                input logic [NUM_SRC-1:0] old);
    lane0 = strb[0] ? data[NUM_SRC-1:0] : old;
  endfunction

  function automatic logic is_chan_value(input logic [ADDR_W-1:0] addr);
    is_chan_value = (addr >= CHAN_VALUE_BASE) &&
                    (addr < CHAN_VALUE_BASE + ADDR_W'(4 * NUM_CHAN)) && (addr[1:0] == 2'h0);
  endfunction

  // Write channel: address and data are latched independently, in any order.
  // A channel is only taken while its ready is shown, so a master that keeps
  // valid up during a pending response is not latched twice.
  wire aw_take = s_axi_awvalid && awready_r;
  wire w_take = s_axi_wvalid && wready_r;
  wire [ADDR_W-1:0] wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0] wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
  wire wr_fire = (aw_held_r || aw_take) && (w_held_r || w_take) && !bvalid_r;
  wire wr_enable = wr_fire && (wr_addr == ENABLE_OFFSET);
  wire wr_flags = wr_fire && (wr_addr == FLAGS_OFFSET);
  wire wr_known = wr_enable || wr_flags;

  // Read channel; channel compare-value reads are decoded for their clearing effect and an OKAY response, and return zero data.
  wire rd_fire = s_axi_arvalid && !rvalid_r;
  wire rd_enable = (s_axi_araddr == ENABLE_OFFSET);
  wire rd_flags = (s_axi_araddr == FLAGS_OFFSET);
  wire rd_chan = is_chan_value(s_axi_araddr);
  wire [1:0] rd_chan_idx = s_axi_araddr[3:2] - CHAN_VALUE_BASE[3:2];
  wire rd_known = rd_enable || rd_flags || rd_chan;
  wire [31:0] rd_data = rd_enable ? {24'h000000, enable_r} :
                        rd_flags ? {24'h000000, flags_r} : 32'h00000000;

  // Update source conditions.
  wire upd_allowed = !update_ctrl.update_disable;
  wire upd_src_all = upd_allowed && !update_ctrl.update_source_select;
  wire upd_set = (upd_allowed && events.rep_overflow) ||
                 (upd_src_all && events.update_generate) ||
                 (upd_src_all && events.trigger_reinit);

  logic [NUM_SRC-1:0] hw_set;
  logic [NUM_SRC-1:0] sw_clr;
  always_comb begin
    hw_set = '0;
    sw_clr = '0;
    hw_set[UPDATE_BIT] = upd_set;
    for (int i = 0; i < NUM_CHAN; i++) begin
      hw_set[CHAN_BIT_LO + i] = events.chan_is_output[i] ? events.chan_match[i]
                                                          : events.chan_capture[i];
      if (rd_fire && rd_chan && (rd_chan_idx == 2'(i))) begin
        sw_clr[CHAN_BIT_LO + i] = 1'b1;
      end
    end
    hw_set[CTRL_UPDATE_BIT] = events.ctrl_update;
    hw_set[TRIGGER_BIT] = events.trigger;
    hw_set[BREAK_BIT] = events.break_active;
    if (wr_flags && wr_strb[0]) begin
      sw_clr = sw_clr | ~wr_data[NUM_SRC-1:0];
    end
    flags_nxt = (flags_r & ~sw_clr) | hw_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
    end else begin
      // Ready flags mirror "not holding and no response pending" as flip-flops.
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
        awready_r <= 1'b0;
        wready_r <= 1'b0;
      end else begin
        if (aw_take) begin
          aw_held_r <= 1'b1;
          awaddr_r <= s_axi_awaddr;
          awready_r <= 1'b0;
        end
        if (w_take) begin
          w_held_r <= 1'b1;
          wdata_r <= s_axi_wdata;
          wstrb_r <= s_axi_wstrb;
          wready_r <= 1'b0;
        end
        if (bvalid_r && s_axi_bready) begin
          bvalid_r <= 1'b0;
          awready_r <= 1'b1;
          wready_r <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
      arready_r <= 1'b1;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_data;
      rresp_r <= rd_known ? RESP_OKAY : RESP_SLVERR;
      arready_r <= 1'b0;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_r <= ENABLE_RESET;
      flags_r <= FLAGS_RESET;
      update_event_r <= 1'b0;
      counter_reinit_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      if (wr_enable) begin
        enable_r <= lane0(wr_strb, wr_data, enable_r);
      end
      flags_r <= flags_nxt;
      update_event_r <= upd_set;
      counter_reinit_r <= upd_src_all && events.update_generate;
      irq_r <= |(flags_nxt & (wr_enable ? lane0(wr_strb, wr_data, enable_r)
                                        : enable_r));
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign update_event = update_event_r;
  assign counter_reinit = counter_reinit_r;
  assign irq = irq_r;

endmodule

//--- verilog/timer_irq_pkg.sv
package timer_irq_pkg;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ENABLE_OFFSET = 8'h10;
  localparam logic [ADDR_W-1:0] FLAGS_OFFSET = 8'h14;
  localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] CHAN_VALUE_BASE = 8'h34;

  localparam int NUM_CHAN = 4;
  localparam int NUM_SRC = 8;

  localparam int UPDATE_BIT = 0;
  localparam int CHAN_BIT_LO = 1;
  localparam int CTRL_UPDATE_BIT = 5;
  localparam int TRIGGER_BIT = 6;
  localparam int BREAK_BIT = 7;

  localparam int UPDATE_DISABLE_BIT = 1;
  localparam int UPDATE_SOURCE_SELECT_BIT = 2;

  localparam logic [NUM_SRC-1:0] ENABLE_RESET = 8'h00;
  localparam logic [NUM_SRC-1:0] FLAGS_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic rep_overflow;
    logic trigger_reinit;
    logic update_generate;
    logic [NUM_CHAN-1:0] chan_match;
    logic [NUM_CHAN-1:0] chan_capture;
    logic [NUM_CHAN-1:0] chan_is_output;
    logic ctrl_update;
    logic trigger;
    logic break_active;
  } timer_events_t;

  typedef struct packed {
    logic update_disable;
    logic update_source_select;
  } update_ctrl_t;

endpackage

//--- test/timer_irq_assertions.sv
module timer_irq_checker
  import timer_irq_pkg::*;
(
  input logic aclk, aresetn,
  input logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input logic [1:0] s_axi_bresp, s_axi_rresp,
  input logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic [31:0] s_axi_rdata,
  input timer_irq_pkg::timer_events_t events,
  input timer_irq_pkg::update_ctrl_t update_ctrl,
  input logic update_event, counter_reinit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rep_src; events.rep_overflow && !update_ctrl.update_disable; endsequence
  sequence s_gen_src; events.update_generate && update_ctrl == 2'h0; endsequence
  property p_rep; s_rep_src |=> update_event; endproperty
  a_rep: assert property (p_rep) else $error("update event missing");
  property p_gen; s_gen_src |=> counter_reinit && update_event; endproperty
  a_gen: assert property (p_gen) else $error("software update missing");
  property p_trg; events.trigger_reinit && update_ctrl == 2'h0 |=> update_event; endproperty
  a_trg: assert property (p_trg) else $error("trigger update missing");
  property p_dis; update_ctrl.update_disable |=> !update_event && !counter_reinit; endproperty
  a_dis: assert property (p_dis) else $error("update while disabled");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_busy: assert property (p_busy) else $error("write accepted while busy");
  property p_unm;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h20 |=>
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not refused");
endmodule

bind timer_irq_enable_status timer_irq_checker u_timer_irq_checker (.*);

//--- test/tb_timer_irq_enable_status.sv
module tb_timer_irq_enable_status;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_irq_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'h51E94368, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic update_event, counter_reinit, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  timer_events_t events = '0;
  update_ctrl_t update_ctrl = '0;
  int fails = 0, n_compared = 0, cyc = 0;
  timer_irq_enable_status u_timer_irq_enable_status (.*);
  always #5 aclk = ~aclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Sources 8 and 9 are the extra update causes, so they land on bit 0.
  function automatic logic [31:0] bitv(input int i);
    return i > 7 ? 32'h1 : 32'h1 << i;
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task results;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task pulse(input int i, input logic o);
    @(posedge aclk);
    case (i)
      0: events.rep_overflow <= 1'b1;
      5: events.ctrl_update <= 1'b1;
      6: events.trigger <= 1'b1;
      7: events.break_active <= 1'b1;
      8: events.update_generate <= 1'b1;
      9: events.trigger_reinit <= 1'b1;
      default: begin
        events.chan_is_output[i-1] <= o;
        events.chan_match[i-1] <= o;
        events.chan_capture[i-1] <= !o;
      end
    endcase
    @(posedge aclk);
    events <= '{break_active: events.break_active, chan_is_output: events.chan_is_output,
                default: 1'b0};
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ENABLE_OFFSET);
    chk("enable reset", {24'h0, ENABLE_RESET}, d);
    rd(FLAGS_OFFSET);
    chk("flags reset", {24'h0, FLAGS_RESET}, d);
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      wr(ENABLE_OFFSET, seed);
      rd(ENABLE_OFFSET);
      chk("enable", {24'h0, seed[7:0]}, d);
      pulse(i, seed[8]);
      rd(FLAGS_OFFSET);
      chk("flag set", bitv(i), d);
      chk("irq", {31'h0, |(bitv(i) & seed)}, {31'h0, irq});
      wr(FLAGS_OFFSET, bitv(i));
      rd(FLAGS_OFFSET);
      chk("flag kept", bitv(i), d);
      if (i == 7) begin
        wr(FLAGS_OFFSET, 32'h0);
        rd(FLAGS_OFFSET);
        chk("break held", bitv(i), d);
        events.break_active <= 1'b0;
        @(posedge aclk);
      end
      if (i inside {[1:4]}) rd(CHAN_VALUE_BASE + 8'(4 * (i - 1)));
      else wr(FLAGS_OFFSET, 32'hFFFFFF00);
      rd(FLAGS_OFFSET);
      chk("flag clear", 32'h0, d);
      chk("irq clear", 32'h0, {31'h0, irq});
    end
    update_ctrl <= 2'h2;
    pulse(0, 1'b0);
    pulse(8, 1'b0);
    pulse(9, 1'b0);
    update_ctrl <= 2'h1;
    pulse(8, 1'b0);
    pulse(9, 1'b0);
    rd(FLAGS_OFFSET);
    chk("gated update", 32'h0, d);
    pulse(0, 1'b0);
    rd(FLAGS_OFFSET);
    chk("overflow update", 32'h1, d);
    rd(8'h20);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    results();
  end
endmodule
